// [verilog/serial_port_pkg.sv]
// Constants, field layouts and carrier types for the serial control port registers
`default_nettype none
package serial_port_pkg;

  localparam int ADDR_W = 10;
  localparam int INSTR_BITS = 16;
  localparam int BYTE_BITS = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_SETUP = 10'h000;
  localparam logic [ADDR_W-1:0] ADDR_VARIANT = 10'h003;
  localparam logic [ADDR_W-1:0] ADDR_READBACK = 10'h004;
  localparam logic [ADDR_W-1:0] ADDR_RESERVED_RO = 10'h1a3;
  localparam logic [ADDR_W-1:0] ADDR_DIVIDE = 10'h1e0;
  localparam logic [ADDR_W-1:0] ADDR_CLK_INPUT = 10'h1e1;
  localparam logic [ADDR_W-1:0] ADDR_POWERDOWN = 10'h230;
  localparam logic [ADDR_W-1:0] ADDR_UPDATE = 10'h232;

  // Field positions of the setup, readback and update registers
  localparam int SETUP_OUT_SEL_BIT = 0;
  localparam int SETUP_LSB_BIT = 1;
  localparam int SETUP_SRST_BIT = 2;
  localparam int SETUP_LONG_BIT = 3;
  localparam int READBACK_BIT = 0;
  localparam int UPDATE_BIT = 0;

  // Instruction word layout
  localparam int INSTR_RW_BIT = 15;
  localparam int INSTR_LEN_HI = 14;
  localparam int INSTR_LEN_LO = 13;
  localparam logic [1:0] LEN_STREAM = 2'h3;

  // Value is arbitrary, not tied to any real part
  localparam logic [7:0] VARIANT_ID = 8'h5a;

  // Reset values
  localparam logic [7:0] DIVIDE_DEFAULT = 8'h02;
  localparam logic [7:0] CLK_INPUT_DEFAULT = 8'h00;
  localparam logic [7:0] POWERDOWN_DEFAULT = 8'h00;
  localparam logic READBACK_DEFAULT = 1'b0;

  typedef struct packed {
    logic soft_reset;
    logic lsb_first;
    logic out_pin_sel;
  } port_setup_t;

  localparam port_setup_t SETUP_DEFAULT = '{soft_reset: 1'b0, lsb_first: 1'b0,
                                            out_pin_sel: 1'b0};

  typedef struct packed {
    logic [7:0] divide_ratio;
    logic [7:0] clock_input;
    logic [7:0] powerdown;
  } tuning_t;

  localparam tuning_t TUNING_DEFAULT = '{divide_ratio: DIVIDE_DEFAULT,
                                         clock_input: CLK_INPUT_DEFAULT,
                                         powerdown: POWERDOWN_DEFAULT};

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic sdio;
  } serial_pins_in_t;

  typedef struct packed {
    logic sdio;
    logic sdio_oe;
    logic serial_output_pin;
    logic serial_output_pin_oe;
  } serial_pins_out_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_INSTR = 4'b0010,
    ST_DATA = 4'b0100,
    ST_DONE = 4'b1000
  } port_state_t;

endpackage
`default_nettype wire

// [verilog/register_store.sv]
// Buffered and active register storage with soft reset and update command
`timescale 1ns/1ps
`default_nettype none
module register_store import serial_port_pkg::*; (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic wr_en_in,
  input wire logic [ADDR_W-1:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  output port_setup_t setup_out,
  output logic readback_sel_out,
  output tuning_t buffered_out,
  output tuning_t active_out,
  output logic update_flag_out
);

  port_setup_t setup_reg, setup_next;
  logic sel_reg, sel_next;
  tuning_t buf_reg, buf_next;
  tuning_t act_reg, act_next;
  logic upd_reg, upd_next;
  logic update_write;

  assign update_write = wr_en_in && (wr_addr_in == ADDR_UPDATE) && wr_data_in[UPDATE_BIT];

  always_comb begin
    setup_next = setup_reg;
    sel_next = sel_reg;
    buf_next = buf_reg;
    act_next = act_reg;
    // Update command bit clears itself
    // self clearing
    upd_next = 1'b0;
    if (wr_en_in) begin
      case (wr_addr_in)
        ADDR_SETUP: begin
          setup_next.soft_reset = wr_data_in[SETUP_SRST_BIT];
          setup_next.lsb_first = wr_data_in[SETUP_LSB_BIT];
          setup_next.out_pin_sel = wr_data_in[SETUP_OUT_SEL_BIT];
        end
        ADDR_READBACK: sel_next = wr_data_in[READBACK_BIT];
        ADDR_DIVIDE: buf_next.divide_ratio = wr_data_in;
        ADDR_CLK_INPUT: buf_next.clock_input = wr_data_in;
        ADDR_POWERDOWN: buf_next.powerdown = wr_data_in;
        ADDR_UPDATE: begin
          if (wr_data_in[UPDATE_BIT]) begin
            act_next = buf_reg;
            upd_next = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    // Held at defaults until the host writes the bit back to zero
    // soft reset restore
    if (setup_next.soft_reset) begin
      setup_next = SETUP_DEFAULT;
      setup_next.soft_reset = 1'b1;
      sel_next = READBACK_DEFAULT;
      buf_next = TUNING_DEFAULT;
      act_next = TUNING_DEFAULT;
      upd_next = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      setup_reg <= SETUP_DEFAULT;
      sel_reg <= READBACK_DEFAULT;
      buf_reg <= TUNING_DEFAULT;
      act_reg <= TUNING_DEFAULT;
      upd_reg <= 1'b0;
    end else begin
      setup_reg <= setup_next;
      sel_reg <= sel_next;
      buf_reg <= buf_next;
      act_reg <= act_next;
      upd_reg <= upd_next;
    end
  end

  assign setup_out = setup_reg;
  assign readback_sel_out = sel_reg;
  assign buffered_out = buf_reg;
  assign active_out = act_reg;
  assign update_flag_out = upd_reg;

  a_update_self_clear: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    upd_reg |=> !upd_reg) else $error("update bit did not clear itself");

  a_update_copy_all: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    update_write && !setup_reg.soft_reset && !wr_data_in[SETUP_SRST_BIT]
    |=> act_reg == $past(buf_reg) && upd_reg) else $error("update did not copy buffers");

  a_active_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !update_write && !setup_next.soft_reset |=> $stable(act_reg))
    else $error("active registers changed without update");

  a_soft_reset_defaults: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    setup_reg.soft_reset |-> buf_reg == TUNING_DEFAULT && act_reg == TUNING_DEFAULT
    && !sel_reg && !setup_reg.lsb_first && !setup_reg.out_pin_sel)
    else $error("soft reset left a register off its default");

endmodule
`default_nettype wire

// [verilog/serial_port_config_regs.sv]
// Serial control port engine with register readback and pin drive control
`timescale 1ns/1ps
`default_nettype none
module serial_port_config_regs import serial_port_pkg::*; (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire serial_pins_in_t pins_in,
  output serial_pins_out_t pins_out,
  output tuning_t tuning_out,
  output logic soft_reset_out
);

  port_state_t state_reg, state_next;
  logic sclk_prev_reg;
  logic [INSTR_BITS-1:0] shift_reg, shift_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic rw_reg, rw_next;
  logic stream_reg, stream_next;
  logic [1:0] left_reg, left_next;
  logic [7:0] tx_reg, tx_next;
  logic out_bit_reg, out_bit_next;
  serial_pins_out_t pins_reg, pins_next;

  logic sclk_rise, sclk_fall;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0] wr_data;
  port_setup_t setup;
  logic readback_sel;
  tuning_t buffered, active;
  logic update_flag;
  logic read_phase;

  register_store register_store_i (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .wr_en_in(wr_en),
    .wr_addr_in(wr_addr),
    .wr_data_in(wr_data),
    .setup_out(setup),
    .readback_sel_out(readback_sel),
    .buffered_out(buffered),
    .active_out(active),
    .update_flag_out(update_flag)
  );

  // LSB-first mode fills from the top so the word ends up in natural order
  function automatic logic [INSTR_BITS-1:0] shift_in(input logic [INSTR_BITS-1:0] value,
                                                     input logic din, input logic lsb);
    shift_in = lsb ? {din, value[INSTR_BITS-1:1]} : {value[INSTR_BITS-2:0], din};
  endfunction

  function automatic logic [7:0] data_byte(input logic [INSTR_BITS-1:0] value,
                                           input logic lsb);
    data_byte = lsb ? value[INSTR_BITS-1:BYTE_BITS] : value[BYTE_BITS-1:0];
  endfunction

  function automatic logic [ADDR_W-1:0] addr_step(input logic [ADDR_W-1:0] a,
                                                  input logic lsb);
    addr_step = lsb ? ADDR_W'(a + 10'h001) : ADDR_W'(a - 10'h001);
  endfunction

  function automatic logic [7:0] read_reg(input logic [ADDR_W-1:0] a,
                                          input port_setup_t s,
                                          input logic sel,
                                          input tuning_t b,
                                          input tuning_t act,
                                          input logic upd);
    tuning_t view;
    view = sel ? act : b;
    read_reg = 8'h00;
    case (a)
      // High nibble reads as the mirror, length bit reads fixed long
      ADDR_SETUP: begin
        read_reg[SETUP_OUT_SEL_BIT] = s.out_pin_sel;
        read_reg[SETUP_LSB_BIT] = s.lsb_first;
        read_reg[SETUP_SRST_BIT] = s.soft_reset;
        read_reg[SETUP_LONG_BIT] = 1'b1;
        read_reg[7:4] = {read_reg[0], read_reg[1], read_reg[2], read_reg[3]};
      end
      ADDR_VARIANT: read_reg = VARIANT_ID;
      ADDR_READBACK: read_reg[READBACK_BIT] = sel;
      ADDR_DIVIDE: read_reg = view.divide_ratio;
      ADDR_CLK_INPUT: read_reg = view.clock_input;
      ADDR_POWERDOWN: read_reg = view.powerdown;
      ADDR_UPDATE: read_reg[UPDATE_BIT] = upd;
      default: read_reg = 8'h00;
    endcase
  endfunction

  assign sclk_rise = pins_in.sclk && !sclk_prev_reg;
  assign sclk_fall = !pins_in.sclk && sclk_prev_reg;

  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    bit_cnt_next = bit_cnt_reg;
    addr_next = addr_reg;
    rw_next = rw_reg;
    stream_next = stream_reg;
    left_next = left_reg;
    tx_next = tx_reg;
    out_bit_next = out_bit_reg;
    wr_en = 1'b0;
    wr_addr = addr_reg;
    wr_data = 8'h00;
    unique case (state_reg)
      ST_IDLE: begin
        if (!pins_in.cs_n) begin
          state_next = ST_INSTR;
          bit_cnt_next = 4'h0;
        end
      end
      ST_INSTR: begin
        if (sclk_rise) begin
          shift_next = shift_in(shift_reg, pins_in.sdio, setup.lsb_first);
          bit_cnt_next = 4'(bit_cnt_reg + 4'h1);
          if (bit_cnt_reg == 4'(INSTR_BITS - 1)) begin
            rw_next = shift_next[INSTR_RW_BIT];
            stream_next = shift_next[INSTR_LEN_HI:INSTR_LEN_LO] == LEN_STREAM;
            left_next = shift_next[INSTR_LEN_HI:INSTR_LEN_LO];
            addr_next = shift_next[ADDR_W-1:0];
            bit_cnt_next = 4'h0;
            state_next = ST_DATA;
            // Line reads low until the first falling edge, never a stale bit
            out_bit_next = 1'b0;
            tx_next = read_reg(shift_next[ADDR_W-1:0], setup, readback_sel,
                               buffered, active, update_flag);
          end
        end
      end
      ST_DATA: begin
        if (sclk_rise) begin
          shift_next = shift_in(shift_reg, pins_in.sdio, setup.lsb_first);
          bit_cnt_next = 4'(bit_cnt_reg + 4'h1);
          if (bit_cnt_reg == 4'(BYTE_BITS - 1)) begin
            bit_cnt_next = 4'h0;
            // Writes to read-only slots fall through the store's decode
            wr_en = !rw_reg;
            wr_data = data_byte(shift_next, setup.lsb_first);
            addr_next = addr_step(addr_reg, setup.lsb_first);
            if (rw_reg) begin
              tx_next = read_reg(addr_next, setup, readback_sel, buffered, active,
                                 update_flag);
            end
            if (!stream_reg) begin
              if (left_reg == 2'h0) begin
                state_next = ST_DONE;
              end else begin
                left_next = 2'(left_reg - 2'h1);
              end
            end
          end
        end else if (sclk_fall && rw_reg) begin
          out_bit_next = setup.lsb_first ? tx_reg[0] : tx_reg[7];
          tx_next = setup.lsb_first ? {1'b0, tx_reg[7:1]} : {tx_reg[6:0], 1'b0};
        end
      end
      ST_DONE: begin
      end
    endcase
    // Deselect aborts any transfer; a partial byte is never written
    if (pins_in.cs_n) begin
      state_next = ST_IDLE;
    end
  end

  // Enables follow the next state so they rise with the read phase itself
  assign read_phase = (state_next == ST_DATA) && rw_next;

  always_comb begin
    pins_next.sdio = out_bit_next;
    pins_next.serial_output_pin = out_bit_next;
    pins_next.sdio_oe = read_phase && !setup.out_pin_sel;
    pins_next.serial_output_pin_oe = read_phase && setup.out_pin_sel;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_reg <= ST_IDLE;
      sclk_prev_reg <= 1'b0;
      shift_reg <= 16'h0000;
      bit_cnt_reg <= 4'h0;
      addr_reg <= 10'h000;
      rw_reg <= 1'b0;
      stream_reg <= 1'b0;
      left_reg <= 2'h0;
      tx_reg <= 8'h00;
      out_bit_reg <= 1'b0;
      pins_reg <= '0;
    end else begin
      state_reg <= state_next;
      sclk_prev_reg <= pins_in.sclk;
      shift_reg <= shift_next;
      bit_cnt_reg <= bit_cnt_next;
      addr_reg <= addr_next;
      rw_reg <= rw_next;
      stream_reg <= stream_next;
      left_reg <= left_next;
      tx_reg <= tx_next;
      out_bit_reg <= out_bit_next;
      pins_reg <= pins_next;
    end
  end

  assign pins_out = pins_reg;
  assign tuning_out = active;
  assign soft_reset_out = setup.soft_reset;

  a_output_pin_idle: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !setup.out_pin_sel && !$past(setup.out_pin_sel) |-> !pins_reg.serial_output_pin_oe)
    else $error("output pin driven in shared-pin mode");

  a_shared_pin_quiet: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    setup.out_pin_sel && $past(setup.out_pin_sel) |-> !pins_reg.sdio_oe)
    else $error("data pin driven in separate-output mode");

  a_instr_length: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    state_reg == ST_INSTR && sclk_rise && bit_cnt_reg == 4'hf && !pins_in.cs_n
    |=> state_reg == ST_DATA && bit_cnt_reg == 4'h0) else $error("instruction not 16 bits");

  a_variant_read: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    state_reg == ST_INSTR && state_next == ST_DATA && rw_next && addr_next == ADDR_VARIANT
    |=> tx_reg == VARIANT_ID) else $error("variant identifier read wrong");

  a_readback_buffered: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    state_reg == ST_INSTR && state_next == ST_DATA && rw_next && !readback_sel
    && addr_next == ADDR_DIVIDE |=> tx_reg == $past(buffered.divide_ratio))
    else $error("buffered readback wrong");

  a_readback_active: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    state_reg == ST_INSTR && state_next == ST_DATA && rw_next && readback_sel
    && addr_next == ADDR_POWERDOWN |=> tx_reg == $past(active.powerdown))
    else $error("active readback wrong");

  a_addr_down: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    state_reg == ST_DATA && sclk_rise && bit_cnt_reg == 4'h7 && !setup.lsb_first
    && !pins_in.cs_n |=> addr_reg == 10'($past(addr_reg) - 10'h001))
    else $error("address did not decrement");

  a_addr_up: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    state_reg == ST_DATA && sclk_rise && bit_cnt_reg == 4'h7 && setup.lsb_first
    && !pins_in.cs_n |=> addr_reg == 10'($past(addr_reg) + 10'h001))
    else $error("address did not increment");

  a_deselect_release: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    pins_in.cs_n |=> state_reg == ST_IDLE && !pins_reg.sdio_oe
    && !pins_reg.serial_output_pin_oe) else $error("deselect left a pin driven");

  a_done_released: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    state_reg == ST_DONE |-> !pins_reg.sdio_oe && !pins_reg.serial_output_pin_oe)
    else $error("pin driven after last byte");

  a_write_phase_quiet: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    state_reg == ST_DATA && !rw_reg |-> !pins_reg.sdio_oe && !pins_reg.serial_output_pin_oe)
    else $error("pin driven during write data");

  a_read_shared_drive: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    state_reg == ST_DATA && rw_reg && !$past(setup.out_pin_sel) |-> pins_reg.sdio_oe)
    else $error("shared pin not driven during read");

  a_read_separate_drive: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    state_reg == ST_DATA && rw_reg && $past(setup.out_pin_sel)
    |-> pins_reg.serial_output_pin_oe) else $error("output pin not driven during read");

  a_msb_first_out: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    state_reg == ST_DATA && rw_reg && sclk_fall && !setup.lsb_first && !pins_in.cs_n
    |=> pins_reg.sdio == $past(tx_reg[7])) else $error("read bit not high first");

  a_lsb_first_out: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    state_reg == ST_DATA && rw_reg && sclk_fall && setup.lsb_first && !pins_in.cs_n
    |=> pins_reg.sdio == $past(tx_reg[0])) else $error("read bit not low first");

  a_instr_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    state_reg == ST_INSTR && !sclk_rise && !pins_in.cs_n
    |=> state_reg == ST_INSTR && $stable(bit_cnt_reg)) else $error("instruction count moved");

  a_setup_readback: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    state_reg == ST_INSTR && state_next == ST_DATA && rw_next && addr_next == ADDR_SETUP
    |=> tx_reg[SETUP_LONG_BIT] && tx_reg[7:4] == {tx_reg[0], tx_reg[1], tx_reg[2], tx_reg[3]})
    else $error("setup readback not long and mirrored");

  a_update_reads_clear: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    state_reg == ST_INSTR && state_next == ST_DATA && rw_next && addr_next == ADDR_UPDATE
    |=> tx_reg == 8'h00) else $error("update bit read back set");

  a_bank_select_read: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    state_reg == ST_INSTR && state_next == ST_DATA && rw_next && addr_next == ADDR_READBACK
    |=> tx_reg == {7'h00, $past(readback_sel)}) else $error("bank select read wrong");

  a_clk_input_buffered: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    state_reg == ST_INSTR && state_next == ST_DATA && rw_next && !readback_sel
    && addr_next == ADDR_CLK_INPUT |=> tx_reg == $past(buffered.clock_input))
    else $error("buffered clock input readback wrong");

endmodule
`default_nettype wire

// [test/serial_host_model.sv]
// Behavioural serial host that frames transfers on the control port pins
`timescale 1ns/1ps
`default_nettype none
module serial_host_model import serial_port_pkg::*; (
  input wire logic clk_in,
  input wire serial_pins_out_t dev_pins_in,
  output var serial_pins_in_t host_pins_out
);
  localparam int HALF = 4;
  logic sclk_q = 1'b0;
  logic cs_n_q = 1'b1;
  logic bit_q = 1'b0;

  // Device owns the shared line while its enable is high
  assign host_pins_out = '{sclk: sclk_q, cs_n: cs_n_q,
                           sdio: dev_pins_in.sdio_oe ? dev_pins_in.sdio : bit_q};

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic xfer(input logic rd, input logic [1:0] len, input logic [9:0] addr,
                      input int n, input logic lsb, input logic sel,
                      input logic [31:0] wd, output logic [31:0] rdat, output logic oe_ok);
    logic [15:0] ins;
    logic [7:0] byt;
    logic en_good;
    int i;
    int k;
    ins = {rd, len, 3'b000, addr};
    rdat = '0;
    oe_ok = 1'b1;
    cs_n_q = 1'b0;
    // whole instruction word reversed in low-first order
    for (i = 0; i < 16; i++) begin
      bit_q = ins[lsb ? i : 15 - i];
      tick(HALF);
      sclk_q = 1'b1;
      tick(HALF);
      sclk_q = 1'b0;
    end
    for (k = 0; k < n; k++) begin
      byt = wd[8*k +: 8];
      for (i = 0; i < 8; i++) begin
        // Released line keeps changing so a stale level never passes
        bit_q = rd ? ~bit_q : byt[lsb ? i : 7 - i];
        tick(HALF);
        // A released pin reads as the inverse of what the host last drove
        if (sel) begin
          rdat[8*k + (lsb ? i : 7 - i)] = dev_pins_in.serial_output_pin_oe ?
                                          dev_pins_in.serial_output_pin : ~bit_q;
        end else begin
          rdat[8*k + (lsb ? i : 7 - i)] = dev_pins_in.sdio_oe ? dev_pins_in.sdio : ~bit_q;
        end
        en_good = sel ? (dev_pins_in.serial_output_pin_oe & ~dev_pins_in.sdio_oe)
                      : (dev_pins_in.sdio_oe & ~dev_pins_in.serial_output_pin_oe);
        if (rd && en_good !== 1'b1) begin
          oe_ok = 1'b0;
        end
        sclk_q = 1'b1;
        tick(HALF);
        sclk_q = 1'b0;
      end
    end
    tick(1);
    cs_n_q = 1'b1;
    bit_q = ~bit_q;
    tick(3);
  endtask
endmodule
`default_nettype wire

// [test/serial_port_config_regs_test.sv]
// Self-checking bench for the serial port configuration register bank
`timescale 1ns/1ps
`default_nettype none
module serial_port_config_regs_test import serial_port_pkg::*;;
  typedef struct {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } row_t;

  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  serial_pins_in_t pins_in;
  serial_pins_out_t pins_out;
  tuning_t tuning_out;
  logic soft_reset_out;
  logic lsb_mode = 1'b0;
  logic sel_mode = 1'b0;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  // Setup value 0x18 keeps the long-instruction bit set and mirrors the nibbles
  row_t rows [7] = '{
    '{ADDR_DIVIDE, 8'h05, 8'h05},
    '{ADDR_CLK_INPUT, 8'ha3, 8'ha3},
    '{ADDR_POWERDOWN, 8'h3c, 8'h3c},
    '{ADDR_VARIANT, 8'hff, VARIANT_ID},
    '{ADDR_RESERVED_RO, 8'hff, 8'h00},
    '{ADDR_SETUP, 8'h18, 8'h18},
    '{ADDR_READBACK, 8'h00, 8'h00}};

  always #2.5 clk_in = ~clk_in;

  serial_port_config_regs serial_port_config_regs_i (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .pins_in(pins_in),
    .pins_out(pins_out),
    .tuning_out(tuning_out),
    .soft_reset_out(soft_reset_out)
  );

  serial_host_model serial_host_model_i (
    .clk_in(clk_in),
    .dev_pins_in(pins_out),
    .host_pins_out(pins_in)
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task tally_and_finish;
    if (err_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic ok;
    serial_host_model_i.xfer(1'b0, 2'b00, a, 1, lsb_mode, sel_mode, {24'h0, d}, r, ok);
  endtask

  task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
    logic [31:0] r;
    logic ok;
    serial_host_model_i.xfer(1'b1, 2'b00, a, 1, lsb_mode, sel_mode, 32'h0, r, ok);
    check(r, {24'h0, e}, "register read");
    check({31'h0, ok}, 32'h1, "read pin enables");
  endtask

  task automatic burst(input logic rdn, input logic [9:0] a, input logic [15:0] d);
    logic [31:0] r;
    logic ok;
    serial_host_model_i.xfer(rdn, 2'b01, a, 2, lsb_mode, sel_mode, {16'h0, d}, r, ok);
    if (rdn) begin
      check(r, {16'h0, d}, "burst read");
    end
  endtask

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      $display("wrong value at %0t: run did not complete", $time);
      tally_and_finish();
    end
  end

  initial begin
    repeat (4) @(posedge clk_in);
    #1 sys_rst_in = 1'b0;
    check({8'h0, tuning_out}, {8'h0, TUNING_DEFAULT}, "reset active values");
    check({31'h0, soft_reset_out}, 32'h0, "reset soft bit");
    check({28'h0, pins_out}, 32'h0, "reset pins");
    repeat (2) @(posedge clk_in);
    #1;
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd_chk(rows[i].addr, rows[i].exp);
      check({8'h0, tuning_out}, {8'h0, TUNING_DEFAULT}, "buffered write leaked");
    end
    wr(ADDR_UPDATE, 8'h01);
    check({8'h0, tuning_out}, 32'h0005_a33c, "update copy");
    rd_chk(ADDR_UPDATE, 8'h00);
    wr(ADDR_DIVIDE, 8'h07);
    rd_chk(ADDR_DIVIDE, 8'h07);
    wr(ADDR_POWERDOWN, 8'hc6);
    rd_chk(ADDR_POWERDOWN, 8'hc6);
    wr(ADDR_READBACK, 8'h01);
    rd_chk(ADDR_DIVIDE, 8'h05);
    rd_chk(ADDR_POWERDOWN, 8'h3c);
    check({24'h0, tuning_out.divide_ratio}, 32'h05, "active before update");
    wr(ADDR_READBACK, 8'h00);
    burst(1'b0, ADDR_CLK_INPUT, 16'h2211);
    burst(1'b1, ADDR_CLK_INPUT, 16'h2211);
    rd_chk(ADDR_DIVIDE, 8'h22);
    // Mirrored setup value decodes alike in either order
    wr(ADDR_SETUP, 8'h5a);
    lsb_mode = 1'b1;
    burst(1'b0, ADDR_DIVIDE, 16'h4433);
    burst(1'b1, ADDR_DIVIDE, 16'h4433);
    wr(ADDR_SETUP, 8'h18);
    lsb_mode = 1'b0;
    rd_chk(ADDR_CLK_INPUT, 8'h44);
    wr(ADDR_SETUP, 8'h99);
    sel_mode = 1'b1;
    rd_chk(ADDR_VARIANT, VARIANT_ID);
    wr(ADDR_SETUP, 8'h18);
    sel_mode = 1'b0;
    rd_chk(ADDR_VARIANT, VARIANT_ID);
    wr(ADDR_UPDATE, 8'h01);
    wr(ADDR_SETUP, 8'h3c);
    check({31'h0, soft_reset_out}, 32'h1, "soft reset held");
    check({8'h0, tuning_out}, {8'h0, TUNING_DEFAULT}, "soft reset actives");
    wr(ADDR_DIVIDE, 8'h77);
    // Host clears the bit itself since it never self clears
    wr(ADDR_SETUP, 8'h18);
    check({31'h0, soft_reset_out}, 32'h0, "soft reset released");
    rd_chk(ADDR_DIVIDE, DIVIDE_DEFAULT);
    rd_chk(ADDR_CLK_INPUT, CLK_INPUT_DEFAULT);
    wr(ADDR_POWERDOWN, 8'h5c);
    wr(ADDR_UPDATE, 8'h01);
    check({8'h0, tuning_out}, 32'h0002_005c, "update after soft reset");
    @(posedge clk_in);
    #1 sys_rst_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #1 sys_rst_in = 1'b0;
    check({8'h0, tuning_out}, {8'h0, TUNING_DEFAULT}, "second reset actives");
    repeat (2) @(posedge clk_in);
    #1;
    rd_chk(ADDR_POWERDOWN, POWERDOWN_DEFAULT);
    tally_and_finish();
  end
endmodule
`default_nettype wire
